// ---- core/msac_pkg.sv ----
// Purpose : Shared constants and types for the channel mux and 8-bit SAR control block
// Assumes : 10 MHz system clock, APB register access, one clock domain
// Notes   : Offsets are byte addresses of aligned 32-bit words
package msac_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] MSAC_OFF_CTRL   = 8'h00;
    localparam logic [7:0] MSAC_OFF_STATUS = 8'h04;
    localparam logic [7:0] MSAC_OFF_RESULT = 8'h08;
    localparam logic [7:0] MSAC_OFF_IRQST  = 8'h0C;
    localparam logic [7:0] MSAC_OFF_IRQMSK = 8'h10;
    // Control fields
    localparam int MSAC_CTRL_FREERUN = 0;
    localparam int MSAC_CTRL_START   = 1;
    // Status fields
    localparam int MSAC_ST_EOC  = 0;
    localparam int MSAC_ST_BUSY = 1;
    // Interrupt fields
    localparam int MSAC_IRQ_DONE  = 0;
    localparam int MSAC_IRQ_ABORT = 1;
    localparam int MSAC_IRQ_W     = 2;
    // Reset values
    localparam logic [1:0] MSAC_CTRL_RST   = 2'h0;
    localparam logic [1:0] MSAC_IRQMSK_RST = 2'h0;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int MSAC_CONV_PERIODS = 64;
    localparam int MSAC_EOC_MAX_LAT  = 8;
    localparam int MSAC_CH_COUNT     = 16;
    localparam int MSAC_RES_W        = 8;
    localparam int MSAC_PER_STEP     = MSAC_CONV_PERIODS / MSAC_RES_W;

    typedef enum logic [1:0] {
        MSAC_IDLE,
        MSAC_ARMED,
        MSAC_CONV
    } msac_state_t;
endpackage

// ---- core/msac_sar_if.sv ----
// Purpose : Carries sequencer signals between the control core and the SAR datapath
// Assumes : Single clock domain
// Notes   : Comparator decision arrives from the analog side
`timescale 1ns/1ps
interface msac_sar_if;
    logic       clear;
    logic       step;
    logic [2:0] bit_idx;
    logic       comp_hi;
    logic [7:0] trial;
    logic [7:0] sar;
    modport ctrl (output clear, output step, output bit_idx, input trial, input sar);
    modport dp   (input clear, input step, input bit_idx, input comp_hi,
                  output trial, output sar);
endinterface

// ---- core/msac_sar_dp.sv ----
// Purpose : Successive-approximation register datapath
// Assumes : Comparator input already synchronised
// Notes   : One bit decided per step, MSB first
`timescale 1ns/1ps
module msac_sar_dp
    import msac_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    msac_sar_if.dp    sar_if
);
    logic [7:0] sar_q;

    // ****************************************************************
    // Trial word and bit decision
    // ****************************************************************
    // Trial sets the bit under test on top of decided bits
    assign sar_if.trial = sar_q | (8'h01 << sar_if.bit_idx);
    assign sar_if.sar   = sar_q;

    // SAR cleared at start, then the trial bit kept on each step with comparator high
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sar_q <= 8'h00;
        end else if (sar_if.clear) begin
            sar_q <= 8'h00;
        end else if (sar_if.step && sar_if.comp_hi) begin
            sar_q <= sar_if.trial;
        end
    end
endmodule

// ---- core/msac_ch_dec.sv ----
// Purpose : Channel address latch and one-hot decoder
// Assumes : Latch strobe and inhibit are already synchronised
// Notes   : Code zero selects the first channel
`timescale 1ns/1ps
module msac_ch_dec
    import msac_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        latch_rise,
    input  wire logic [3:0]  sel_in,
    input  wire logic        mux_enable,
    output logic      [3:0]  sel_q,
    output logic      [15:0] ch_on
);
    // Captured on each latch rise, held otherwise
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sel_q <= 4'h0;
        end else if (latch_rise) begin
            sel_q <= sel_in;
        end
    end

    // One channel on, or none when inhibited
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ch_on <= 16'h0000;
        end else if (!mux_enable) begin
            ch_on <= 16'h0000;
        end else begin
            ch_on <= 16'h0001 << sel_q;
        end
    end
endmodule

// ---- core/msac_top.sv ----
// Purpose : Channel select, SAR conversion sequencer, result latch and APB registers
// Assumes : 10 MHz clk, all controller and comparator pins synchronised by two flops before use; APB inputs are used directly
// Notes   : One clock domain; reset is asynchronous, active high
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module msac_top
    import msac_pkg::*;
#(
    parameter int RES_W = MSAC_RES_W
)(
    input  wire logic        clk,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins from the controller and comparator
    input  wire logic [3:0]  channel_select_bits,
    input  wire logic        addr_latch,
    input  wire logic        mux_enable,
    input  wire logic        start_pin,
    input  wire logic        out_enable,
    input  wire logic        comp_hi,
    // Pins to the controller and analog side
    output logic      [15:0] ch_on,
    output logic      [7:0]  data_o,
    output logic      [7:0]  data_oe,
    output logic             eoc,
    output logic             irq
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [3:0] sel_m_q, sel_s_q;
    logic [4:0] pin_m_q, pin_s_q;
    logic       comp_m_q, comp_s_q;
    logic       latch_d1_q, start_d1_q;

    // Two flops per pin, first stage read only by second
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sel_m_q  <= 4'h0;
            sel_s_q  <= 4'h0;
            pin_m_q  <= 5'h00;
            pin_s_q  <= 5'h00;
            comp_m_q <= 1'b0;
            comp_s_q <= 1'b0;
        end else begin
            sel_m_q  <= channel_select_bits;
            sel_s_q  <= sel_m_q;
            pin_m_q  <= {addr_latch, mux_enable, start_pin, out_enable, 1'b0};
            pin_s_q  <= pin_m_q;
            comp_m_q <= comp_hi;
            comp_s_q <= comp_m_q;
        end
    end

    logic latch_s, mux_en_s, start_ext_s, oe_s;
    assign latch_s     = pin_s_q[4];
    assign mux_en_s    = pin_s_q[3];
    assign start_ext_s = pin_s_q[2];
    assign oe_s        = pin_s_q[1];

    // ****************************************************************
    // Registers and start source
    // ****************************************************************
    logic [1:0]       ctrl_q;
    logic [1:0]       irq_st_q, irq_msk_q;
    logic [RES_W-1:0] result_q;
    logic             eoc_q;
    logic             start_lvl;
    logic             latch_rise, start_rise, start_fall;

    // Free-run feeds the end flag back to start
    assign start_lvl = start_ext_s | ctrl_q[MSAC_CTRL_START]
                     | (ctrl_q[MSAC_CTRL_FREERUN] & eoc_q);

    // Edge history of strobes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            latch_d1_q <= 1'b0;
            start_d1_q <= 1'b0;
        end else begin
            latch_d1_q <= latch_s;
            start_d1_q <= start_lvl;
        end
    end

    assign latch_rise = latch_s & ~latch_d1_q;
    assign start_rise = start_lvl & ~start_d1_q;
    assign start_fall = ~start_lvl & start_d1_q;

    // ****************************************************************
    // Channel decoder
    // ****************************************************************
    logic [3:0] sel_q;

    msac_ch_dec u_dec (
        .clk        (clk),
        .reset      (reset),
        .latch_rise (latch_rise),
        .sel_in     (sel_s_q),
        .mux_enable (mux_en_s),
        .sel_q      (sel_q),
        .ch_on      (ch_on)
    );

    // ****************************************************************
    // Conversion sequencer
    // ****************************************************************
    msac_sar_if sar_if ();
    assign sar_if.comp_hi = comp_s_q;

    msac_sar_dp u_dp (
        .clk    (clk),
        .reset  (reset),
        .sar_if (sar_if)
    );

    msac_state_t state_q;
    logic [5:0]  cyc_q;
    logic        busy;
    logic        done;
    logic        abort;

    assign busy  = (state_q != MSAC_IDLE);
    assign done  = (state_q == MSAC_CONV) && (cyc_q == 6'(MSAC_CONV_PERIODS - 1));
    assign abort = start_rise && busy;

    // Start rise arms and aborts; fall begins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= MSAC_IDLE;
        end else if (start_rise) begin
            state_q <= MSAC_ARMED;
        end else begin
            unique case (state_q)
                MSAC_IDLE:  state_q <= MSAC_IDLE;
                MSAC_ARMED: if (start_fall) begin
                    state_q <= MSAC_CONV;
                end
                MSAC_CONV:  if (done) begin
                    state_q <= MSAC_IDLE;
                end
            endcase
        end
    end

    // Period counter, 64 periods per conversion
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cyc_q <= 6'h00;
        end else if (state_q != MSAC_CONV) begin
            cyc_q <= 6'h00;
        end else begin
            cyc_q <= cyc_q + 6'h01;
        end
    end

    // One bit decided at the end of each eight-period slot
    assign sar_if.clear   = start_rise;
    assign sar_if.bit_idx = 3'(7 - (cyc_q / MSAC_PER_STEP));
    assign sar_if.step    = (state_q == MSAC_CONV)
                          && (cyc_q % MSAC_PER_STEP == MSAC_PER_STEP - 1);

    // End flag falls at the start rise, rises at completion
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            eoc_q <= 1'b1;
        end else if (start_rise) begin
            eoc_q <= 1'b0;
        end else if (done) begin
            eoc_q <= 1'b1;
        end
    end
    assign eoc = eoc_q;

    // Result latched only on completion, abort leaves it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            result_q <= '0;
        end else if (done) begin
            result_q <= (sar_if.step && comp_s_q) ? sar_if.trial : sar_if.sar;
        end
    end

    // Three-state outputs, MSB on first data line
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            data_o  <= 8'h00;
            data_oe <= 8'h00;
        end else begin
            data_o  <= result_q;
            data_oe <= {8{oe_s}};
        end
    end

    // ****************************************************************
    // APB slave and interrupts
    // ****************************************************************
    logic acc, rd_st;
    assign acc     = psel && penable;
    assign pready  = 1'b1;
    assign rd_st   = acc && !pwrite && (paddr == MSAC_OFF_IRQST);
    assign pslverr = acc && !(paddr == MSAC_OFF_CTRL || paddr == MSAC_OFF_STATUS
                           || paddr == MSAC_OFF_RESULT || paddr == MSAC_OFF_IRQST
                           || paddr == MSAC_OFF_IRQMSK);

    // Control and mask writes; software start self-clears
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_q    <= MSAC_CTRL_RST;
            irq_msk_q <= MSAC_IRQMSK_RST;
        end else begin
            ctrl_q[MSAC_CTRL_START] <= 1'b0;
            if (acc && pwrite && paddr == MSAC_OFF_CTRL) begin
                ctrl_q <= pwdata[1:0];
            end
            if (acc && pwrite && paddr == MSAC_OFF_IRQMSK) begin
                irq_msk_q <= pwdata[1:0];
            end
        end
    end

    // Sticky events, read clears, new event wins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_st_q <= 2'h0;
        end else begin
            irq_st_q <= (rd_st ? 2'h0 : irq_st_q) | {abort, done};
        end
    end
    // A set mask bit hides its source from the interrupt line
    assign irq = |(irq_st_q & ~irq_msk_q);

    // Read data registered in the setup phase, ready for the access phase
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                MSAC_OFF_CTRL:   prdata <= {30'h0, ctrl_q};
                MSAC_OFF_STATUS: prdata <= {26'h0, sel_q, busy, eoc_q};
                MSAC_OFF_RESULT: prdata <= {24'h0, result_q};
                MSAC_OFF_IRQST:  prdata <= {30'h0, irq_st_q};
                MSAC_OFF_IRQMSK: prdata <= {30'h0, irq_msk_q};
                default:         prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_eoc_falls: assert property (@(posedge clk) disable iff (reset)
        start_rise |=> !eoc_q) else $error("end flag did not fall after start");
    a_conv_len: assert property (@(posedge clk) disable iff (reset)
        done |-> ($past(state_q, 64) == MSAC_ARMED) && $past(state_q == MSAC_CONV, 63))
        else $error("conversion length not 64 periods");
    a_eoc_done: assert property (@(posedge clk) disable iff (reset)
        done && !start_rise |=> eoc_q) else $error("end flag not high after done");
    a_abort_keep: assert property (@(posedge clk) disable iff (reset)
        !done |=> $stable(result_q)) else $error("result changed without completion");
    a_begin_fall: assert property (@(posedge clk) disable iff (reset)
        $rose(state_q == MSAC_CONV) |-> $past(start_fall)) else $error("began without fall");
    a_abort_rst: assert property (@(posedge clk) disable iff (reset)
        abort |=> state_q == MSAC_ARMED) else $error("abort did not restart");
    a_sar_clear: assert property (@(posedge clk) disable iff (reset)
        start_rise |=> sar_if.sar == 8'h00) else $error("SAR not cleared");
    a_oe_drive: assert property (@(posedge clk) disable iff (reset)
        !oe_s |=> data_oe == 8'h00) else $error("data driven while disabled");
    a_inhibit: assert property (@(posedge clk) disable iff (reset)
        !mux_en_s |=> ch_on == 16'h0000) else $error("channel on while inhibited");
    a_one_hot: assert property (@(posedge clk) disable iff (reset)
        mux_en_s |=> ch_on == (16'h0001 << $past(sel_q))) else $error("wrong channel");
    a_latch_hold: assert property (@(posedge clk) disable iff (reset)
        !latch_rise |=> $stable(sel_q)) else $error("select changed without latch");

    c_full_conv: cover property (@(posedge clk) disable iff (reset) done);
    c_abort:     cover property (@(posedge clk) disable iff (reset) abort);
    c_freerun:   cover property (@(posedge clk) disable iff (reset)
        done ##1 ctrl_q[MSAC_CTRL_FREERUN]);
    c_irq:       cover property (@(posedge clk) disable iff (reset) $rose(irq));
endmodule

// ---- test/msac_ctl_model.sv ----
// Purpose : Controller and comparator model that drives the pin side of msac_top
// Assumes : Tasks are called just after a rising clk edge
// Notes   : Select bits are inverted once the latch hold time has run out
`timescale 1ns/1ps
module msac_ctl_model (
    input  wire logic       clk,
    output logic      [3:0] sel_bits,
    output logic            addr_latch,
    output logic            mux_enable,
    output logic            start_pin,
    output logic            out_enable,
    output logic            comp_hi
);
    // ************************************************************
    // Pin levels and controller sequences
    // ************************************************************
    // Quiet levels at time zero
    initial begin
        sel_bits   = 4'h0;
        addr_latch = 1'b0;
        mux_enable = 1'b0;
        start_pin  = 1'b0;
        out_enable = 1'b0;
        comp_hi    = 1'b0;
    end

    // Code stands a full cycle around the latch edge, then settle time
    task automatic latch_channel(input logic [3:0] code);
        sel_bits <= code;
        @(posedge clk);
        addr_latch <= 1'b1;
        @(posedge clk);
        addr_latch <= 1'b0;
        @(posedge clk);
        sel_bits <= ~code;
        repeat (25) @(posedge clk);
    endtask

    // Start pulse of width cycles; low edge only after the hold time
    task automatic start_pulse(input int width);
        start_pin <= 1'b1;
        repeat (width) @(posedge clk);
        start_pin <= 1'b0;
    endtask
endmodule

// ---- test/tb_msac_top.sv ----
// Purpose : Self-checking bench for msac_top over APB and its pins
// Assumes : comp_hi high keeps each trial bit, mask bit high hides a source
// Notes   : 200 ns start pulses are two clk cycles
`timescale 1ns/1ps
module tb_msac_top;
    import msac_pkg::*;
    logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, last_err, eoc, irq, ab, ae, am, as, ao, ac;
    logic [3:0]  sb;
    logic [15:0] ch_on;
    logic [7:0]  data_o, data_oe;
    int          bad_count = 0, checks_done = 0, n;

    always #50 clk = ~clk; // bench runs the core faster than the pin limit

    msac_ctl_model i_msac_ctl_model (.clk(clk), .sel_bits(sb), .addr_latch(ab),
        .mux_enable(am), .start_pin(as), .out_enable(ao), .comp_hi(ac));

    msac_top i_msac_top (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .channel_select_bits(sb), .addr_latch(ab),
        .mux_enable(am), .start_pin(as), .out_enable(ao), .comp_hi(ac), .ch_on(ch_on),
        .data_o(data_o), .data_oe(data_oe), .eoc(eoc), .irq(irq));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    // Compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        if (k >= 50) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, 32'(pready), 32'h1);
        end
        r = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask

    // Edges until eoc reaches lvl, bounded
    task automatic wt(input logic lvl);
        n = 0;
        while (eoc !== lvl && n < 300) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic wrap_up;
        $display("Counts: checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of about a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up();
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk(32'(eoc), 32'h1);
        rd(MSAC_OFF_CTRL, 32'(MSAC_CTRL_RST));
        rd(MSAC_OFF_IRQMSK, 32'(MSAC_IRQMSK_RST));
        rd(8'h14, 32'h0);
        chk(32'(last_err), 32'h1);
        // Decoder over all codes, then inhibit
        i_msac_ctl_model.mux_enable <= 1'b1;
        for (int c = 0; c < MSAC_CH_COUNT; c++) begin
            i_msac_ctl_model.latch_channel(c[3:0]);
            chk(32'(ch_on), 32'(16'h1 << c));
        end
        i_msac_ctl_model.mux_enable <= 1'b0;
        repeat (6) @(posedge clk);
        chk(32'(ch_on), 32'h0);
        // Plain conversion, all trials kept
        i_msac_ctl_model.comp_hi <= 1'b1;
        fork
            i_msac_ctl_model.start_pulse(2);
            wt(1'b0);
        join
        chk(32'(n >= 1 && n <= MSAC_EOC_MAX_LAT), 32'h1);
        wt(1'b1);
        chk(32'(n >= MSAC_CONV_PERIODS && n <= MSAC_CONV_PERIODS + 8), 32'h1);
        rd(MSAC_OFF_RESULT, 32'hFF);
        chk(32'(irq), 32'h1);
        i_msac_ctl_model.out_enable <= 1'b1;
        repeat (6) @(posedge clk);
        chk(32'({data_o, data_oe}), 32'hFFFF);
        i_msac_ctl_model.out_enable <= 1'b0;
        repeat (6) @(posedge clk);
        chk(32'(data_oe), 32'h0);
        // Interrupt masked, unmasked, cleared by read
        apb(1'b1, MSAC_OFF_IRQMSK, 32'h3);
        chk(32'(irq), 32'h0);
        apb(1'b1, MSAC_OFF_IRQMSK, 32'h0);
        chk(32'(irq), 32'h1);
        rd(MSAC_OFF_IRQST, 32'h1);
        rd(MSAC_OFF_IRQST, 32'h0);
        chk(32'(irq), 32'h0);
        // Abort mid-conversion; old result stays until restart ends
        i_msac_ctl_model.comp_hi <= 1'b0;
        i_msac_ctl_model.start_pulse(2);
        repeat (20) @(posedge clk);
        rd(MSAC_OFF_RESULT, 32'hFF);
        i_msac_ctl_model.start_pulse(2);
        wt(1'b1);
        chk(32'(n >= MSAC_CONV_PERIODS && n < 300), 32'h1);
        rd(MSAC_OFF_RESULT, 32'h00);
        rd(MSAC_OFF_IRQST, 32'h3);
        // Software start, then free-running loop
        apb(1'b1, MSAC_OFF_CTRL, 32'h2);
        wt(1'b0);
        chk(32'(n <= 12), 32'h1);
        wt(1'b1);
        i_msac_ctl_model.comp_hi <= 1'b1;
        apb(1'b1, MSAC_OFF_CTRL, 32'h1);
        i_msac_ctl_model.start_pulse(2);
        wt(1'b1);
        wt(1'b0);
        chk(32'(n <= 12), 32'h1);
        apb(1'b1, MSAC_OFF_CTRL, 32'h0);
        wt(1'b1);
        rd(MSAC_OFF_RESULT, 32'hFF);
        wrap_up();
    end
endmodule
